// ---- core/meter_error_defines.svh ----
// Register offsets, masks, reset values, timing and event codes of the error flag bank
`ifndef METER_ERROR_DEFINES_SVH
`define METER_ERROR_DEFINES_SVH

// Register byte offsets
`define REG_PRIMARY 5'h00
`define REG_LEGACY 5'h04
`define REG_GENERAL 5'h08
`define REG_FILTER 5'h0c
`define REG_DURATION 5'h10
`define REG_IRQ_STATUS 5'h14
`define REG_IRQ_CLEAR 5'h18
`define REG_IRQ_ENABLE 5'h1c

// Flag word layout
`define FLAG_WIDTH 32
`define FATAL_FAULT_MASK 32'h00000f00
`define GENERAL_LOW_MASK 32'h000000ff
`define CRITICAL_MASK 32'h00000f00
`define GENERAL_HIGH_MASK 32'h0000f000
`define WIRED_BUS_MASK 32'hffff0000
`define NO_BITS 32'h00000000

// Reset values
`define FILTER_RESET 32'hffffffff
`define DURATION_RESET 16'h03e8
`define IRQ_ENABLE_RESET 4'h0

// Timing
`define CLK_PERIOD_NS 10
`define DURATION_TICK_NS 1000000

// Interrupt status bits
`define IRQ_COUNT 4
`define IRQ_EVENT_BIT 3

// Event codes
`define EVENT_COUNT 4
`define EVT_SIGNAL_NORMAL 10'h1d0
`define EVT_PHASE_SEQ_END 10'h1d1
`define EVT_NON_LEGAL_RESTART 10'h1d2
`define EVT_ALARM_INPUT_2 10'h1d5

`endif

// ---- core/meter_error_pkg.sv ----
// Types shared by the error flag bank files
`default_nettype none
package meter_error_pkg;

    // Register bus request
    typedef struct packed {
        logic [4:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // Flag sources of one register: pulse requests and persisting conditions
    typedef struct packed {
        logic [31:0] set;
        logic [31:0] cond;
    } flag_src_type;

    // Logged event
    typedef struct packed {
        logic valid;
        logic [9:0] code;
    } event_out_type;

    // Signal strength supervision states
    typedef enum logic [1:0] {
        STRENGTH_NORMAL = 2'b00,
        STRENGTH_LOW = 2'b01,
        STRENGTH_RECOVER = 2'b10
    } strength_state_type;

endpackage
`default_nettype wire

// ---- core/error_flag_bank.sv ----
// One sticky 32-bit error flag register with clear, lock and self-clear logic
`timescale 1ns/1ps
`default_nettype none
module error_flag_bank #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] SELF_CLEAR = '0,
    parameter logic [WIDTH-1:0] LOCK = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Flag sources
    input wire logic [WIDTH-1:0] set_req,
    input wire logic [WIDTH-1:0] cond,
    input wire logic [WIDTH-1:0] report_mask,
    // Software clear
    input wire logic clear_wr,
    input wire logic [WIDTH-1:0] clear_data,
    // State
    output logic [WIDTH-1:0] flags,
    output logic new_flag
);
    logic [WIDTH-1:0] raise; // Bits asked to be set this cycle
    logic [WIDTH-1:0] clear_req; // Bits cleared by a zero write
    logic [WIDTH-1:0] auto_clear; // Self-clearing bits whose cause is gone
    logic [WIDTH-1:0] next_flags;

    // Next flag value
    always_comb begin
        raise = (set_req | cond) & report_mask;
        // Writing zero clears, writing one keeps; locked bits ignore it
        clear_req = clear_wr ? (~clear_data & ~LOCK) : '0;
        auto_clear = SELF_CLEAR & ~cond & ~LOCK;
        // Set wins over any clear in the same cycle
        next_flags = (flags & ~clear_req & ~auto_clear) | raise;
    end

    // Flag storage
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            flags <= '0;
        end else begin
            flags <= next_flags;
        end
    end

    // Pulse when any bit newly rises
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            new_flag <= 1'b0;
        end else begin
            new_flag <= |(next_flags & ~flags);
        end
    end
endmodule
`default_nettype wire

// ---- core/strength_recovery_timer.sv ----
// Watches link signal strength and pulses once it has recovered long enough
`timescale 1ns/1ps
`default_nettype none
`include "meter_error_defines.svh"
module strength_recovery_timer #(
    parameter int TICK_CYCLES = `DURATION_TICK_NS / `CLK_PERIOD_NS,
    parameter int DUR_WIDTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Supervision input and setting
    input wire logic strength_low,
    input wire logic [DUR_WIDTH-1:0] duration,
    // Recovery pulse
    output logic recovered
);
    import meter_error_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES + 1);

    strength_state_type state; // Supervision state
    logic [TICK_W-1:0] tick_count; // Millisecond divider
    logic tick; // One-cycle duration tick
    logic [DUR_WIDTH-1:0] good_ms; // Time spent above threshold

    // Duration tick divider
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tick_count <= '0;
            tick <= 1'b0;
        end else if (tick_count == TICK_W'(TICK_CYCLES - 1)) begin
            tick_count <= '0;
            tick <= 1'b1;
        end else begin
            tick_count <= tick_count + 1'b1;
            tick <= 1'b0;
        end
    end

    // Low, recovering and normal tracking
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state <= STRENGTH_NORMAL;
            good_ms <= '0;
            recovered <= 1'b0;
        end else begin
            recovered <= 1'b0;
            case (state)
                STRENGTH_NORMAL: begin
                    // Low strength arms the recovery watch
                    if (strength_low) begin
                        state <= STRENGTH_LOW;
                    end
                end
                STRENGTH_LOW: begin
                    if (!strength_low) begin
                        state <= STRENGTH_RECOVER;
                        good_ms <= '0;
                    end
                end
                STRENGTH_RECOVER: begin
                    if (strength_low) begin
                        // Drop back, the good time restarts
                        state <= STRENGTH_LOW;
                    end else if (good_ms > duration) begin
                        state <= STRENGTH_NORMAL;
                        recovered <= 1'b1;
                    end else if (tick) begin
                        good_ms <= good_ms + 1'b1;
                    end
                end
                default: begin
                    state <= STRENGTH_NORMAL;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- core/meter_error_flag_registers.sv ----
// Error flag register bank with event log, register port and interrupt
// Operation
// - log 464 after strength recovers long enough
// - log 465 when wrong phase sequence ends
// - log 466 on non-legal part restart
// - log 469 on second alarm input signal
// - malfunction events set their flag bit
// - each error register is 32 bits
// - bits grouped: general, critical, wired bus
// - some flags clear themselves when cause gone
// - other flags stay set until cleared
// - fatal bits 8 to 11 never clear in the first register
// - persisting condition sets the flag again
// - configurable filter may hide errors
// - three error register objects exist
// - third register flags grid monitor deviations
// - only first register strictly required
`timescale 1ns/1ps
`default_nettype none
`include "meter_error_defines.svh"
module meter_error_flag_registers #(
    parameter int TICK_CYCLES = `DURATION_TICK_NS / `CLK_PERIOD_NS,
    parameter logic [`FLAG_WIDTH-1:0] SELF_CLEAR_PRIMARY = `NO_BITS,
    parameter logic [`FLAG_WIDTH-1:0] SELF_CLEAR_LEGACY = `NO_BITS,
    parameter logic [`FLAG_WIDTH-1:0] SELF_CLEAR_GENERAL = `NO_BITS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port
    input wire meter_error_pkg::reg_req_type bus_req,
    output logic [31:0] rd_data,
    // Flag sources: primary, legacy, general (grid monitor deviations)
    input wire meter_error_pkg::flag_src_type primary_src,
    input wire meter_error_pkg::flag_src_type legacy_src,
    input wire meter_error_pkg::flag_src_type general_src,
    // Supervision inputs on this clock
    input wire logic strength_low,
    input wire logic phase_seq_wrong,
    input wire logic non_legal_part_restart,
    // Alarm input pin, asynchronous
    input wire logic second_alarm_input_terminal,
    // Event log
    output meter_error_pkg::event_out_type event_out,
    // Interrupt
    output logic irq
);
    import meter_error_pkg::*;

    localparam int BANKS = 3;

    // Offset of each flag register
    function automatic logic [4:0] bank_offset(input int idx);
        if (idx == 0) begin
            bank_offset = `REG_PRIMARY;
        end else if (idx == 1) begin
            bank_offset = `REG_LEGACY;
        end else begin
            bank_offset = `REG_GENERAL;
        end
    endfunction

    // Event code of each pending slot
    function automatic logic [9:0] event_code(input logic [1:0] idx);
        case (idx)
            2'h0: event_code = `EVT_SIGNAL_NORMAL;
            2'h1: event_code = `EVT_PHASE_SEQ_END;
            2'h2: event_code = `EVT_NON_LEGAL_RESTART;
            default: event_code = `EVT_ALARM_INPUT_2;
        endcase
    endfunction

    flag_src_type bank_src [BANKS]; // Sources per bank
    logic [`FLAG_WIDTH-1:0] bank_flags [BANKS]; // Flag values per bank
    logic [BANKS-1:0] bank_new; // New flag pulses
    logic [BANKS-1:0] bank_wr; // Clear write per bank
    logic [31:0] report_mask; // Filter: one reports the bit
    logic [15:0] duration; // Recovery duration in ms
    logic [`IRQ_COUNT-1:0] irq_status; // Sticky interrupt causes
    logic [`IRQ_COUNT-1:0] irq_enable; // Interrupt enables
    logic [`IRQ_COUNT-1:0] irq_raise; // Causes this cycle
    logic [`IRQ_COUNT-1:0] irq_clear; // Clear request this cycle
    logic [`IRQ_COUNT-1:0] next_irq_status;
    logic alarm_meta; // Pin synchroniser, first stage
    logic alarm_sync; // Pin synchroniser, second stage
    logic alarm_prev; // Edge detector history
    logic phase_prev; // Previous phase sequence level
    logic recovered; // Strength recovery pulse
    logic [`EVENT_COUNT-1:0] event_raise; // Events this cycle
    logic [`EVENT_COUNT-1:0] event_pend; // Events waiting to be logged
    logic [`EVENT_COUNT-1:0] event_pick; // One-hot slot logged now
    logic [1:0] pick_idx; // Index of that slot
    logic [`EVENT_COUNT-1:0] next_event_pend;

    assign bank_src[0] = primary_src;
    assign bank_src[1] = legacy_src;
    assign bank_src[2] = general_src;

    // Three flag registers; fatal bits locked in the first only
    generate
        for (genvar g = 0; g < BANKS; g++) begin : g_bank
            localparam logic [`FLAG_WIDTH-1:0] LOCK_MASK =
                (g == 0) ? `FATAL_FAULT_MASK : `NO_BITS;
            localparam logic [`FLAG_WIDTH-1:0] SELF_MASK =
                (g == 0) ? SELF_CLEAR_PRIMARY :
                (g == 1) ? SELF_CLEAR_LEGACY : SELF_CLEAR_GENERAL;

            assign bank_wr[g] = bus_req.wr && (bus_req.addr == bank_offset(g));

            error_flag_bank #(
                .WIDTH(`FLAG_WIDTH),
                .SELF_CLEAR(SELF_MASK),
                .LOCK(LOCK_MASK)
            ) u_bank (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .set_req(bank_src[g].set),
                .cond(bank_src[g].cond),
                .report_mask(report_mask),
                .clear_wr(bank_wr[g]),
                .clear_data(bus_req.wdata),
                .flags(bank_flags[g]),
                .new_flag(bank_new[g])
            );
        end
    endgenerate

    // Strength recovery supervision
    strength_recovery_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .DUR_WIDTH(16)
    ) u_strength (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .strength_low(strength_low),
        .duration(duration),
        .recovered(recovered)
    );

    // Alarm pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            alarm_meta <= 1'b0;
            alarm_sync <= 1'b0;
        end else begin
            alarm_meta <= second_alarm_input_terminal;
            alarm_sync <= alarm_meta;
        end
    end

    // Edge history of alarm and phase sequence
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            alarm_prev <= 1'b0;
            phase_prev <= 1'b0;
        end else begin
            alarm_prev <= alarm_sync;
            phase_prev <= phase_seq_wrong;
        end
    end

    // Event detection
    always_comb begin
        event_raise[0] = recovered;
        event_raise[1] = phase_prev && !phase_seq_wrong;
        event_raise[2] = non_legal_part_restart;
        event_raise[3] = alarm_sync && !alarm_prev;
    end

    // Pick the lowest pending slot
    always_comb begin
        event_pick = '0;
        pick_idx = 2'h0;
        for (int i = `EVENT_COUNT - 1; i >= 0; i--) begin
            if (event_pend[i]) begin
                event_pick = '0;
                event_pick[i] = 1'b1;
                pick_idx = 2'(i);
            end
        end
        // New events are kept even when their slot is logged now
        next_event_pend = (event_pend & ~event_pick) | event_raise;
    end

    // Pending events
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            event_pend <= '0;
        end else begin
            event_pend <= next_event_pend;
        end
    end

    // Event log output, one code per cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            event_out <= '0;
        end else begin
            event_out.valid <= |event_pend;
            event_out.code <= (|event_pend) ? event_code(pick_idx) : 10'h000;
        end
    end

    // Filter and duration settings
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            report_mask <= `FILTER_RESET;
            duration <= `DURATION_RESET;
        end else if (bus_req.wr) begin
            if (bus_req.addr == `REG_FILTER) begin
                report_mask <= bus_req.wdata;
            end else if (bus_req.addr == `REG_DURATION) begin
                duration <= bus_req.wdata[15:0];
            end
        end
    end

    // Interrupt enable register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_enable <= `IRQ_ENABLE_RESET;
        end else if (bus_req.wr && bus_req.addr == `REG_IRQ_ENABLE) begin
            irq_enable <= bus_req.wdata[`IRQ_COUNT-1:0];
        end
    end

    // Interrupt status next value
    always_comb begin
        irq_raise = {(|event_raise), bank_new};
        if (bus_req.wr && bus_req.addr == `REG_IRQ_CLEAR) begin
            irq_clear = bus_req.wdata[`IRQ_COUNT-1:0];
        end else begin
            irq_clear = '0;
        end
        // A cause in the clearing cycle survives
        next_irq_status = (irq_status & ~irq_clear) | irq_raise;
    end

    // Interrupt status and output
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq <= |(next_irq_status & irq_enable);
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rd_data <= 32'h00000000;
        end else if (bus_req.rd) begin
            if (bus_req.addr == `REG_PRIMARY) begin
                rd_data <= bank_flags[0];
            end else if (bus_req.addr == `REG_LEGACY) begin
                rd_data <= bank_flags[1];
            end else if (bus_req.addr == `REG_GENERAL) begin
                rd_data <= bank_flags[2];
            end else if (bus_req.addr == `REG_FILTER) begin
                rd_data <= report_mask;
            end else if (bus_req.addr == `REG_DURATION) begin
                rd_data <= {16'h0000, duration};
            end else if (bus_req.addr == `REG_IRQ_STATUS) begin
                rd_data <= {28'h0000000, irq_status};
            end else if (bus_req.addr == `REG_IRQ_ENABLE) begin
                rd_data <= {28'h0000000, irq_enable};
            end else begin
                // Unmapped and write-only offsets read zero
                rd_data <= 32'h00000000;
            end
        end else begin
            rd_data <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ---- sim/meter_error_assertions.sv ----
// Port-level checker of the error flag register bank
`timescale 1ns/1ps
`default_nettype none
`include "meter_error_defines.svh"
module meter_error_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port
    input wire meter_error_pkg::reg_req_type bus_req,
    input wire logic [31:0] rd_data,
    // Flag sources
    input wire meter_error_pkg::flag_src_type primary_src,
    input wire meter_error_pkg::flag_src_type legacy_src,
    input wire meter_error_pkg::flag_src_type general_src,
    // Supervision inputs
    input wire logic strength_low,
    input wire logic phase_seq_wrong,
    input wire logic non_legal_part_restart,
    input wire logic second_alarm_input_terminal,
    // Outputs
    input wire meter_error_pkg::event_out_type event_out,
    input wire logic irq
);
    import meter_error_pkg::*;
    logic [31:0] filt; // Shadow of the report mask
    logic [31:0] fatal_seen; // Fatal bits raised so far
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Track report mask writes
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            filt <= `FILTER_RESET;
        end else if (bus_req.wr && bus_req.addr == `REG_FILTER) begin
            filt <= bus_req.wdata;
        end
    end
    // Remember every fatal bit that was reported
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            fatal_seen <= `NO_BITS;
        end else begin
            fatal_seen <= fatal_seen | ((primary_src.set | primary_src.cond) & filt & `FATAL_FAULT_MASK);
        end
    end
    property p_rd_idle;
        !bus_req.rd |=> rd_data == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");
    property p_set;
        primary_src.set[0] && filt[0] ##1 (bus_req.rd && bus_req.addr == `REG_PRIMARY)
            |=> rd_data[0];
    endproperty
    a_set: assert property (p_set) else $error("set request not seen in flags");
    property p_fatal;
        bus_req.rd && bus_req.addr == `REG_PRIMARY |=> (rd_data & $past(fatal_seen)) == $past(fatal_seen);
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal flag lost");
    property p_cond_hold;
        bus_req.rd && bus_req.addr == `REG_PRIMARY && primary_src.cond[12] && $past(filt[12])
            && $past(primary_src.cond[12]) && $past(rst_b) |=> rd_data[12];
    endproperty
    a_cond_hold: assert property (p_cond_hold) else $error("flag low while condition held");
    property p_restart;
        non_legal_part_restart |-> ##[2:8] (event_out.valid && event_out.code == `EVT_NON_LEGAL_RESTART);
    endproperty
    a_restart: assert property (p_restart) else $error("restart event missing");
    property p_phase;
        $fell(phase_seq_wrong) && $past(rst_b) |-> ##[1:8]
            (event_out.valid && event_out.code == `EVT_PHASE_SEQ_END);
    endproperty
    a_phase: assert property (p_phase) else $error("phase sequence end event missing");
    property p_alarm;
        $rose(second_alarm_input_terminal) && $past(rst_b) |-> ##[2:10]
            (event_out.valid && event_out.code == `EVT_ALARM_INPUT_2);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm input event missing");
    property p_evt_code;
        (event_out.valid && event_out.code inside {`EVT_SIGNAL_NORMAL, `EVT_PHASE_SEQ_END,
            `EVT_NON_LEGAL_RESTART, `EVT_ALARM_INPUT_2}) || (!event_out.valid && event_out.code == 10'h0);
    endproperty
    a_evt_code: assert property (p_evt_code) else $error("bad event code");
    c_restart: cover property (event_out.valid && event_out.code == `EVT_NON_LEGAL_RESTART);
    c_strength: cover property (event_out.valid && event_out.code == `EVT_SIGNAL_NORMAL);
    c_irq: cover property ($rose(irq));
endmodule
bind meter_error_flag_registers meter_error_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus_req(bus_req), .rd_data(rd_data), .primary_src(primary_src), .legacy_src(legacy_src),
    .general_src(general_src), .strength_low(strength_low), .phase_seq_wrong(phase_seq_wrong),
    .non_legal_part_restart(non_legal_part_restart),
    .second_alarm_input_terminal(second_alarm_input_terminal), .event_out(event_out), .irq(irq));
`default_nettype wire

// ---- sim/mgmt_client_model.sv ----
// Management client model that drives the register port
`timescale 1ns/1ps
`default_nettype none
module mgmt_client_model (
    // Clock
    input wire logic ref_clk,
    // Register port
    output var meter_error_pkg::reg_req_type bus_req,
    input wire logic [31:0] rd_data
);
    import meter_error_pkg::*;
    // Idle bus from time zero
    initial begin
        bus_req = '0;
    end
    // One-cycle write; each zero bit asks for a clear
    task wr(input logic [4:0] a, input logic [31:0] d);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        bus_req.wdata <= ~d;
    endtask
    // One-cycle read; data taken in the following cycle
    task rd(input logic [4:0] a, output logic [31:0] d);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        @(posedge ref_clk);
        d = rd_data;
    endtask
endmodule
`default_nettype wire

// ---- sim/meter_error_flag_registers_tb.sv ----
// Self-checking bench of the error flag register bank
`timescale 1ns/1ps
`default_nettype none
`include "meter_error_defines.svh"
module meter_error_flag_registers_tb;
    import meter_error_pkg::*;
    localparam int TICK = 4; // Shortened ms tick
    logic ref_clk;
    logic rst_b;
    reg_req_type bus_req; // Driven by the client model
    logic [31:0] rd_data;
    flag_src_type src [3]; // Primary, legacy, general sources
    logic strength_low;
    logic phase_seq_wrong;
    logic non_legal_part_restart;
    logic second_alarm_input_terminal;
    event_out_type event_out;
    logic irq;
    logic [31:0] v; // Last read word
    int bad_count;
    int samples_checked;
    int b;
    logic [4:0] bank_addr [3] = '{`REG_PRIMARY, `REG_LEGACY, `REG_GENERAL};
    // Bit 2 of the primary bank clears itself
    meter_error_flag_registers #(.TICK_CYCLES(TICK), .SELF_CLEAR_PRIMARY(32'h00000004)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .primary_src(src[0]), .legacy_src(src[1]), .general_src(src[2]),
        .strength_low(strength_low), .phase_seq_wrong(phase_seq_wrong),
        .non_legal_part_restart(non_legal_part_restart),
        .second_alarm_input_terminal(second_alarm_input_terminal),
        .event_out(event_out), .irq(irq));
    mgmt_client_model client (.ref_clk(ref_clk), .bus_req(bus_req), .rd_data(rd_data));
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Compare and count
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Read a register and compare
    task rchk(input string name, input logic [4:0] a, input logic [31:0] exp);
        client.rd(a, v);
        chk(name, exp, v);
    endtask
    // One-cycle set pulse on one bank
    task pulse(input int n, input logic [31:0] m);
        src[n].set <= m;
        @(posedge ref_clk);
        src[n].set <= 32'h0;
    endtask
    // Wait for the next logged event and check code and delay
    task evt(input logic [9:0] code, input int lo, input int hi);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (event_out.valid !== 1'b1 && n < hi);
        chk("event_code", {22'h0, code}, {22'h0, event_out.code});
        chk("event_early", 32'h0, {31'h0, n < lo});
    endtask
    // Verdict and end of run
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        close_out;
    end
    // Main sequence
    initial begin
        bad_count = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        src = '{default: '0};
        strength_low = 1'b0;
        phase_seq_wrong = 1'b0;
        non_legal_part_restart = 1'b0;
        second_alarm_input_terminal = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        // Reset values and refused accesses
        rchk("filter", `REG_FILTER, `FILTER_RESET);
        rchk("duration", `REG_DURATION, {16'h0, `DURATION_RESET});
        rchk("irq_enable", `REG_IRQ_ENABLE, 32'h0);
        rchk("irq_clear", `REG_IRQ_CLEAR, 32'h0);
        client.wr(`REG_IRQ_STATUS, 32'hf);
        rchk("irq_status", `REG_IRQ_STATUS, 32'h0);
        rchk("unmapped", 5'h1e, 32'h0);
        // Sticky flags in all three banks, general and wired bus groups
        for (b = 0; b < 3; b++) begin
            rchk("bank_reset", bank_addr[b], 32'h0);
            pulse(b, 32'h00022001);
            rchk("bank_set", bank_addr[b], 32'h00022001);
            repeat (3) @(posedge ref_clk);
            rchk("bank_stay", bank_addr[b], 32'h00022001);
            client.wr(bank_addr[b], ~32'h1);
            rchk("bank_clr1", bank_addr[b], 32'h00022000);
            client.wr(bank_addr[b], 32'h0);
            rchk("bank_clr", bank_addr[b], 32'h0);
        end
        // Set and clear in the same cycle
        src[0].set <= 32'h00001000;
        client.wr(`REG_PRIMARY, 32'h0);
        src[0].set <= 32'h0;
        rchk("set_wins", `REG_PRIMARY, 32'h00001000);
        // Persisting condition sets the flag again
        src[0].cond <= 32'h00001000;
        repeat (2) @(posedge ref_clk);
        client.wr(`REG_PRIMARY, 32'h0);
        rchk("cond_reset", `REG_PRIMARY, 32'h00001000);
        src[0].cond <= 32'h0;
        client.wr(`REG_PRIMARY, 32'h0);
        rchk("cond_gone", `REG_PRIMARY, 32'h0);
        // Self-clearing bit drops with its cause
        src[0].cond <= 32'h00000004;
        repeat (2) @(posedge ref_clk);
        rchk("self_set", `REG_PRIMARY, 32'h00000004);
        src[0].cond <= 32'h0;
        repeat (2) @(posedge ref_clk);
        rchk("self_clr", `REG_PRIMARY, 32'h0);
        // Filtered bit never sets
        client.wr(`REG_FILTER, ~32'h2);
        pulse(0, 32'h00000002);
        rchk("filtered", `REG_PRIMARY, 32'h0);
        client.wr(`REG_FILTER, `FILTER_RESET);
        // Fatal bits ignore clears
        pulse(0, `FATAL_FAULT_MASK);
        client.wr(`REG_PRIMARY, 32'h0);
        rchk("fatal", `REG_PRIMARY, `FATAL_FAULT_MASK);
        // Interrupt masked, enabled, cleared
        client.wr(`REG_IRQ_CLEAR, 32'hf);
        rchk("status_clr", `REG_IRQ_STATUS, 32'h0);
        non_legal_part_restart <= 1'b1;
        @(posedge ref_clk);
        non_legal_part_restart <= 1'b0;
        evt(`EVT_NON_LEGAL_RESTART, 2, 8);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rchk("status_evt", `REG_IRQ_STATUS, 32'h8);
        client.wr(`REG_IRQ_ENABLE, 32'h8);
        repeat (3) @(posedge ref_clk);
        chk("irq_on", 32'h1, {31'h0, irq});
        client.wr(`REG_IRQ_CLEAR, 32'h8);
        repeat (3) @(posedge ref_clk);
        chk("irq_off", 32'h0, {31'h0, irq});
        // Two events at once come out lowest code first
        phase_seq_wrong <= 1'b1;
        repeat (2) @(posedge ref_clk);
        phase_seq_wrong <= 1'b0;
        non_legal_part_restart <= 1'b1;
        @(posedge ref_clk);
        non_legal_part_restart <= 1'b0;
        evt(`EVT_PHASE_SEQ_END, 1, 8);
        evt(`EVT_NON_LEGAL_RESTART, 1, 2);
        // Alarm input rise
        second_alarm_input_terminal <= 1'b1;
        evt(`EVT_ALARM_INPUT_2, 2, 10);
        second_alarm_input_terminal <= 1'b0;
        // Strength recovery longer than two ms
        client.wr(`REG_DURATION, 32'h2);
        strength_low <= 1'b1;
        repeat (3) @(posedge ref_clk);
        strength_low <= 1'b0;
        evt(`EVT_SIGNAL_NORMAL, 2 * TICK, 3 * TICK + 20);
        close_out;
    end
endmodule
`default_nettype wire
